// File: logic/lum_temp_defs.vh
/*
  Constants for the luminance and temperature-sensor register group:
  register indexes, field positions, reset values and bus answers.
  Assumes byte address = 4 * register index on a 32-bit register bus.
*/
`ifndef LUM_TEMP_DEFS_VH
`define LUM_TEMP_DEFS_VH

// Register indexes
`define IDX_LUM_REF      6'h0f
`define IDX_DIM          6'h10
`define IDX_GAIN         6'h11
`define IDX_OFFSET       6'h12
`define IDX_UPDATE       6'h13
`define IDX_READOUT      6'h14
`define IDX_PWRDN        6'h15

// Reset values
`define RST_LUM_REF      8'h30
`define RST_DIM          7'h64
`define RST_GAIN         6'h1e
`define RST_OFFSET       8'h88
`define RST_UPDATE       8'hff
`define RST_PWRDN        8'h00
`define RST_READOUT      8'h00

// Field positions
`define COARSE_MSB       7
`define COARSE_LSB       5
`define FINE_MSB         4
`define FINE_LSB         0
`define DIM_MSB          6
`define GAIN_MSB         5
`define PD_CUR_LIMIT     7
`define PD_MAX_CURRENT   6
`define PD_CATHODE_GEN   5
`define PD_VOLT_REF      4
`define PD_GAMMA_SENSOR  3
`define PD_CATHODE_SENS  2
`define PD_TEMP_SENSOR   1
`define PD_TEMP_REF      0

// Coarse current factors in units of 1/32
`define COARSE_F0        8'h00
`define COARSE_F1        8'h10
`define COARSE_F2        8'h30
`define COARSE_F3        8'h50
`define COARSE_F4        8'h70
`define FACTOR_SHIFT     5
`define DIM_PERCENT      23'h000064

// Cathode supply mode, first automatic regulation
`define MODE_FIRST_AUTO_REGULATION       2'b00

// Bus answers
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// File: logic/temp_readout_calc.v
/*
  Temperature readout arithmetic: scaled sensor term plus constant
  plus offset, saturated to the 8-bit range.
  Assumes the sensor code is already in the clock domain.
*/
`timescale 1ns/1ps
module temp_readout_calc #(
  parameter integer        GAIN_SHIFT = 4,
  parameter signed [17:0]  CONST_TERM = 18'sd0
) (
  input  wire [7:0] sensor_code,
  input  wire [5:0] temp_gain_divider,
  input  wire [7:0] temp_offset_adjust,
  output reg  [7:0] readout_value
);
  wire        [13:0] gain_prod;
  reg  signed [17:0] scaled;
  reg  signed [17:0] sum;

  // Full 14-bit product; a self-sized product would lose its top bits
  assign gain_prod = sensor_code * temp_gain_divider;

  always @* begin
    scaled = $signed({4'h0, gain_prod}) >>> GAIN_SHIFT;
    sum    = scaled + CONST_TERM + $signed({10'h000, temp_offset_adjust});
    if (sum < 18'sd0) begin
      readout_value = 8'h00;
    end else if (sum > 18'sd255) begin
      readout_value = 8'hff;
    end else begin
      readout_value = sum[7:0];
    end
  end
endmodule // temp_readout_calc

// File: logic/luminance_temp_sensor_regs.v
/*
  Luminance, temperature-sensor and analogue power-down register group
  behind an AXI4-Lite slave, with frame-paced temperature readout.
  Assumes frame_vsync and sensor_code arrive asynchronously from the
  display timing and sensor converter; cathode_supply_mode is on clock.

*/
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "lum_temp_defs.vh"
module luminance_temp_sensor_regs #(
  parameter integer        ADDR_W     = 8,
  parameter [15:0]         REF_LUM    = 16'd1500,
  parameter integer        GAIN_SHIFT = 4,
  parameter signed [17:0]  CONST_TERM = 18'sd0
) (
  input  wire              clock,
  input  wire              sys_rst,
  input  wire [ADDR_W-1:0] awaddr,
  input  wire [2:0]        awprot,
  input  wire              awvalid,
  output wire              awready,
  input  wire [31:0]       wdata,
  input  wire [3:0]        wstrb,
  input  wire              wvalid,
  output wire              wready,
  output reg  [1:0]        bresp,
  output reg               bvalid,
  input  wire              bready,
  input  wire [ADDR_W-1:0] araddr,
  input  wire [2:0]        arprot,
  input  wire              arvalid,
  output wire              arready,
  output reg  [31:0]       rdata,
  output reg  [1:0]        rresp,
  output reg               rvalid,
  input  wire              rready,
  input  wire              frame_vsync,
  input  wire [7:0]        sensor_code,
  input  wire [1:0]        cathode_supply_mode,
  output wire [2:0]        coarse_current_factor,
  output wire [4:0]        fine_current_factor,
  output reg  [15:0]       max_luminance,
  output reg  [15:0]       dimmed_luminance,
  output wire [5:0]        temp_gain_divider,
  output wire [7:0]        temp_offset_adjust,
  output wire [7:0]        temp_readout,
  output reg               readout_refreshed,
  output wire              current_limit_sensor_off,
  output wire              max_current_function_off,
  output wire              cathode_generator_off,
  output wire              voltage_reference_off,
  output wire              gamma_sensor_off,
  output wire              cathode_sensor_off,
  output wire              temp_sensor_off,
  output wire              temp_reference_off
);
  // Register storage
  reg  [7:0]        lum_ref_ff;
  reg  [6:0]        dim_ff;
  reg  [5:0]        gain_ff;
  reg  [7:0]        offset_ff;
  reg  [7:0]        update_ff;
  reg  [7:0]        readout_ff;
  reg  [7:0]        pwrdn_ff;

  // Write channel holding state
  reg               aw_held_ff;
  reg  [5:0]        aw_idx_ff;
  reg               aw_low_ff;
  reg               w_held_ff;
  reg  [31:0]       w_data_ff;
  reg               w_strb0_ff;

  // Synchronisers and frame counting
  reg               vs_meta_ff;
  reg               vs_sync_ff;
  reg               vs_prev_ff;
  reg  [7:0]        code_meta_ff;
  reg  [7:0]        code_sync_ff;
  reg  [7:0]        frame_cnt_ff;
  reg  [7:0]        nxt_frame_cnt;
  reg               nxt_refresh;

  // Luminance pipeline
  reg  [7:0]        factor_ff;
  reg  [7:0]        coarse_f;
  reg  [15:0]       nxt_max_lum;
  reg  [15:0]       nxt_dimmed;
  reg  [23:0]       lum_prod;
  reg  [22:0]       dim_prod;
  reg  [22:0]       dim_quot;

  wire [7:0]        calc_value;
  wire              frame_edge;
  wire              do_write;
  wire [5:0]        ar_idx;
  reg  [7:0]        rd_value;
  reg               rd_hit;
  reg               wr_hit;

  assign awready = !aw_held_ff && !bvalid;
  assign wready  = !w_held_ff && !bvalid;
  assign arready = !rvalid;
  assign do_write = aw_held_ff && w_held_ff && !bvalid;
  assign ar_idx   = araddr[7:2];

  // Write address and data taken in either order
  always @(posedge clock) begin
    if (sys_rst) begin
      aw_held_ff <= 1'b0;
      aw_idx_ff  <= 6'h00;
      aw_low_ff  <= 1'b0;
      w_held_ff  <= 1'b0;
      w_data_ff  <= 32'h00000000;
      w_strb0_ff <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held_ff <= 1'b1;
        aw_idx_ff  <= awaddr[7:2];
        aw_low_ff  <= (awaddr[1:0] == 2'b00);
      end else if (do_write) begin
        aw_held_ff <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held_ff  <= 1'b1;
        w_data_ff  <= wdata;
        w_strb0_ff <= wstrb[0];
      end else if (do_write) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  always @* begin
    case (aw_idx_ff)
      `IDX_LUM_REF, `IDX_DIM, `IDX_GAIN, `IDX_OFFSET,
      `IDX_UPDATE, `IDX_READOUT, `IDX_PWRDN: wr_hit = aw_low_ff;
      default: wr_hit = 1'b0;
    endcase
  end

  // Write response follows both halves
  always @(posedge clock) begin
    if (sys_rst) begin
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // Register writes; byte lane 0 carries every field
  always @(posedge clock) begin
    if (sys_rst) begin
      lum_ref_ff <= `RST_LUM_REF;
      dim_ff     <= `RST_DIM;
      gain_ff    <= `RST_GAIN;
      offset_ff  <= `RST_OFFSET;
      update_ff  <= `RST_UPDATE;
      pwrdn_ff   <= `RST_PWRDN;
    end else if (do_write && wr_hit && w_strb0_ff) begin
      case (aw_idx_ff)
        `IDX_LUM_REF: lum_ref_ff <= w_data_ff[7:0];
        `IDX_DIM:     dim_ff     <= w_data_ff[`DIM_MSB:0];
        `IDX_GAIN:    gain_ff    <= w_data_ff[`GAIN_MSB:0];
        `IDX_OFFSET:  offset_ff  <= w_data_ff[7:0];
        // Values below 02h are the host's fault; stored as written
        `IDX_UPDATE:  update_ff  <= w_data_ff[7:0];
        `IDX_PWRDN:   pwrdn_ff   <= w_data_ff[7:0];
        default:      lum_ref_ff <= lum_ref_ff; // Readout is read-only
      endcase
    end
  end

  // Read decode; reserved bits read as zero
  always @* begin
    rd_hit   = (araddr[1:0] == 2'b00);
    rd_value = 8'h00;
    case (ar_idx)
      `IDX_LUM_REF: rd_value = lum_ref_ff;
      `IDX_DIM:     rd_value = {1'b0, dim_ff};
      `IDX_GAIN:    rd_value = {2'b00, gain_ff};
      `IDX_OFFSET:  rd_value = offset_ff;
      `IDX_UPDATE:  rd_value = update_ff;
      `IDX_READOUT: rd_value = readout_ff;
      `IDX_PWRDN:   rd_value = pwrdn_ff;
      default:      rd_hit   = 1'b0;
    endcase
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_hit ? {24'h000000, rd_value} : 32'h00000000;
      rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // Asynchronous pins pass two flops first
  always @(posedge clock) begin
    if (sys_rst) begin
      vs_meta_ff   <= 1'b0;
      vs_sync_ff   <= 1'b0;
      vs_prev_ff   <= 1'b0;
      code_meta_ff <= 8'h00;
      code_sync_ff <= 8'h00;
    end else begin
      vs_meta_ff   <= frame_vsync;
      vs_sync_ff   <= vs_meta_ff;
      vs_prev_ff   <= vs_sync_ff;
      code_meta_ff <= sensor_code;
      code_sync_ff <= code_meta_ff;
    end
  end

  // Rising edge of vertical timing marks a frame
  assign frame_edge = vs_sync_ff && !vs_prev_ff;

  temp_readout_calc #(
    .GAIN_SHIFT (GAIN_SHIFT),
    .CONST_TERM (CONST_TERM)
  ) u_calc (
    .sensor_code        (code_sync_ff),
    .temp_gain_divider  (gain_ff),
    .temp_offset_adjust (offset_ff),
    .readout_value      (calc_value)
  );

  // Compare with >= so a shortened interval never strands the count
  always @* begin
    nxt_frame_cnt = frame_cnt_ff;
    nxt_refresh   = 1'b0;
    if (frame_edge) begin
      if (frame_cnt_ff >= update_ff) begin
        nxt_frame_cnt = 8'h00;
        nxt_refresh   = !pwrdn_ff[`PD_TEMP_SENSOR];
      end else begin
        nxt_frame_cnt = frame_cnt_ff + 8'h01;
      end
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      frame_cnt_ff      <= 8'h00;
      readout_ff        <= `RST_READOUT;
      readout_refreshed <= 1'b0;
    end else begin
      frame_cnt_ff      <= nxt_frame_cnt;
      readout_refreshed <= nxt_refresh;
      if (nxt_refresh) begin
        readout_ff <= calc_value;
      end
    end
  end

  // Coarse codes above 4 are held at the top factor
  always @* begin
    case (lum_ref_ff[`COARSE_MSB:`COARSE_LSB])
      3'h0:    coarse_f = `COARSE_F0;
      3'h1:    coarse_f = `COARSE_F1;
      3'h2:    coarse_f = `COARSE_F2;
      3'h3:    coarse_f = `COARSE_F3;
      default: coarse_f = `COARSE_F4;
    endcase
  end

  always @* begin
    lum_prod    = REF_LUM * factor_ff;
    nxt_max_lum = lum_prod[`FACTOR_SHIFT+15:`FACTOR_SHIFT];
    dim_prod    = max_luminance * dim_ff;
    dim_quot    = dim_prod / `DIM_PERCENT;
    if (cathode_supply_mode == `MODE_FIRST_AUTO_REGULATION) begin
      nxt_dimmed = dim_quot[15:0];
    end else begin
      nxt_dimmed = max_luminance;
    end
  end

  // Three-stage pipeline keeps the multipliers off one path
  always @(posedge clock) begin
    if (sys_rst) begin
      factor_ff        <= 8'h00;
      max_luminance    <= 16'h0000;
      dimmed_luminance <= 16'h0000;
    end else begin
      factor_ff        <= coarse_f + {3'b000, lum_ref_ff[`FINE_MSB:`FINE_LSB]};
      max_luminance    <= nxt_max_lum;
      dimmed_luminance <= nxt_dimmed;
    end
  end

  assign coarse_current_factor    = lum_ref_ff[`COARSE_MSB:`COARSE_LSB];
  assign fine_current_factor      = lum_ref_ff[`FINE_MSB:`FINE_LSB];
  assign temp_gain_divider        = gain_ff;
  assign temp_offset_adjust       = offset_ff;
  assign temp_readout             = readout_ff;
  assign current_limit_sensor_off = pwrdn_ff[`PD_CUR_LIMIT];
  assign max_current_function_off = pwrdn_ff[`PD_MAX_CURRENT];
  assign cathode_generator_off    = pwrdn_ff[`PD_CATHODE_GEN];
  assign voltage_reference_off    = pwrdn_ff[`PD_VOLT_REF];
  assign gamma_sensor_off         = pwrdn_ff[`PD_GAMMA_SENSOR];
  assign cathode_sensor_off       = pwrdn_ff[`PD_CATHODE_SENS];
  assign temp_sensor_off          = pwrdn_ff[`PD_TEMP_SENSOR];
  assign temp_reference_off       = pwrdn_ff[`PD_TEMP_REF];

endmodule // luminance_temp_sensor_regs

// File: bench/luminance_temp_sensor_regs_assertions.sv
/* Port-level checker for the luminance and temperature register group.
   Assumes one clock and the synchronous reset sys_rst; bound below. */
`timescale 1ns/1ps
module luminance_temp_sensor_regs_assertions (
  input wire        clock,
  input wire        sys_rst,
  input wire        awvalid,
  input wire        awready,
  input wire        wvalid,
  input wire        wready,
  input wire [1:0]  bresp,
  input wire        bvalid,
  input wire        bready,
  input wire        arvalid,
  input wire        arready,
  input wire [31:0] rdata,
  input wire        rvalid,
  input wire        rready,
  input wire [1:0]  cathode_supply_mode,
  input wire [15:0] max_luminance,
  input wire [15:0] dimmed_luminance,
  input wire [7:0]  temp_readout,
  input wire        readout_refreshed,
  input wire        temp_sensor_off
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_wr_take; awvalid && awready && wvalid && wready; endsequence
  sequence s_b_wait; bvalid && !bready; endsequence
  sequence s_r_wait; rvalid && !rready; endsequence
  sequence s_manual; (cathode_supply_mode != 2'h0) && $stable(max_luminance); endsequence
  property p_wr_resp; s_wr_take |-> ##2 bvalid; endproperty
  property p_b_hold; s_b_wait |=> bvalid && $stable(bresp); endproperty
  property p_r_hold; s_r_wait |=> rvalid && $stable(rdata); endproperty
  property p_aw_block; bvalid |-> !awready && !wready; endproperty
  property p_ar_block; rvalid |-> !arready; endproperty
  property p_rd_resp; arvalid && arready |=> rvalid && rdata[31:8] == 24'h0; endproperty
  property p_dim; s_manual [*3] |-> dimmed_luminance == max_luminance; endproperty
  property p_ro_chg; !$stable(temp_readout) |-> readout_refreshed; endproperty
  property p_pulse; readout_refreshed |=> !readout_refreshed; endproperty
  property p_pd; $past(temp_sensor_off) |-> !readout_refreshed; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  a_aw_block: assert property (p_aw_block) else $error("write taken while answer pending");
  a_ar_block: assert property (p_ar_block) else $error("read taken while answer pending");
  a_rd_resp: assert property (p_rd_resp) else $error("read data bad");
  a_dim: assert property (p_dim) else $error("dimming outside mode zero");
  a_ro_chg: assert property (p_ro_chg) else $error("readout moved off refresh");
  a_pulse: assert property (p_pulse) else $error("refresh pulse too long");
  a_pd: assert property (p_pd) else $error("refresh while sensor off");
endmodule // luminance_temp_sensor_regs_assertions
bind luminance_temp_sensor_regs luminance_temp_sensor_regs_assertions u_chk (
  .clock(clock), .sys_rst(sys_rst), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .cathode_supply_mode(cathode_supply_mode), .max_luminance(max_luminance),
  .dimmed_luminance(dimmed_luminance), .temp_readout(temp_readout),
  .readout_refreshed(readout_refreshed), .temp_sensor_off(temp_sensor_off));

// File: bench/testbench.sv
/* Self-checking bench for the register group: AXI4-Lite master tasks,
   frame pulses and sensor code driven here. Needs the design and checker. */
`timescale 1ns/1ps
module testbench;
  logic        clock = 0, sys_rst = 1;
  logic [7:0]  awaddr = 0, araddr = 0, sensor_code = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        frame_vsync = 0;
  logic [31:0] wdata = 0;
  logic [1:0]  cathode_supply_mode = 0;
  wire         awready, wready, bvalid, arready, rvalid, readout_refreshed;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [15:0] max_luminance, dimmed_luminance;
  wire  [7:0]  pd, temp_readout, ofs;
  wire  [5:0]  gain;
  wire  [4:0]  fine;
  wire  [2:0]  coarse;
  int          miscompares = 0, num_checks = 0, refr = 0;
  // Negative constant so the low clamp is reachable
  luminance_temp_sensor_regs #(.CONST_TERM(-18'sd100)) u_luminance_temp_sensor_regs (
    .clock(clock), .sys_rst(sys_rst), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .frame_vsync(frame_vsync), .sensor_code(sensor_code),
    .cathode_supply_mode(cathode_supply_mode), .coarse_current_factor(coarse),
    .fine_current_factor(fine), .max_luminance(max_luminance),
    .dimmed_luminance(dimmed_luminance), .temp_gain_divider(gain),
    .temp_offset_adjust(ofs), .temp_readout(temp_readout),
    .readout_refreshed(readout_refreshed), .current_limit_sensor_off(pd[7]),
    .max_current_function_off(pd[6]), .cathode_generator_off(pd[5]),
    .voltage_reference_off(pd[4]), .gamma_sensor_off(pd[3]), .cathode_sensor_off(pd[2]),
    .temp_sensor_off(pd[1]), .temp_reference_off(pd[0]));
  always #4 clock = ~clock;
  always @(posedge clock) if (readout_refreshed === 1'h1) refr <= refr + 1;
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Response ready offered with the request and held until the answer
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
    int n;
    @(posedge clock);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1; n = 0;
    do begin
      @(posedge clock); n++;
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!(bvalid === 1'h1 && bready === 1'h1) && n < 50);
    bready <= 0;
    chk("bvalid", bvalid, 1'b1);
    chk("bresp", bresp, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
    int n;
    @(posedge clock);
    araddr <= a; arvalid <= 1; rready <= 1; n = 0;
    do begin
      @(posedge clock); n++;
      if (arready) arvalid <= 0;
    end while (!(rvalid === 1'h1 && rready === 1'h1) && n < 50);
    rready <= 0;
    chk("rvalid", rvalid, 1'b1);
    chk("rresp", rresp, e);
    chk("rdata", rdata, {24'h0, d});
  endtask
  task automatic frames(input int k);
    repeat (k) begin
      @(posedge clock) frame_vsync <= 1;
      repeat (4) @(posedge clock);
      frame_vsync <= 0;
      repeat (6) @(posedge clock);
    end
  endtask
  function automatic logic [7:0] ro(input int c, input int g, input int o);
    int v;
    v = ((c * g) >>> 4) - 100 + o;
    ro = v < 0 ? 8'h00 : (v > 255 ? 8'hff : v[7:0]);
  endfunction
  task automatic t_reset;
    logic [7:0] rv [7];
    rv = '{8'h30, 8'h64, 8'h1e, 8'h88, 8'hff, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) rd(8'(8'h3c + 4 * i), rv[i], 2'h0);
    rd(8'h58, 8'h00, 2'h2);
    wr(8'h41, 8'h11, 2'h2);
    rd(8'h40, 8'h64, 2'h0);
    chk("coarse", coarse, 3'h1);
    chk("fine", fine, 5'h10);
    chk("max", max_luminance, 16'd1500);
    chk("dim", dimmed_luminance, 16'd1500);
  endtask
  task automatic t_regs;
    logic [7:0] mk [7];
    mk = '{8'hff, 8'h7f, 8'h3f, 8'hff, 8'hff, 8'h00, 8'hff};
    for (int i = 0; i < 7; i++) begin
      wr(8'(8'h3c + 4 * i), 8'hff, 2'h0);
      rd(8'(8'h3c + 4 * i), mk[i], 2'h0);
    end
    chk("gain", gain, 6'h3f);
    chk("ofs", ofs, 8'hff);
    chk("pd", pd, 8'hff);
    wr(8'h54, 8'ha5, 2'h0);
    chk("pd", pd, 8'ha5);
    wr(8'h54, 8'h00, 2'h0);
    chk("pd", pd, 8'h00);
  endtask
  task automatic t_lum;
    int cf [5];
    cf = '{0, 16, 48, 80, 112};
    for (int c = 0; c < 5; c++) begin
      wr(8'h3c, {3'(c), 5'h05}, 2'h0);
      repeat (4) @(posedge clock);
      chk("max", max_luminance, (1500 * (cf[c] + 5)) >> 5);
    end
    wr(8'h3c, 8'h30, 2'h0);
    wr(8'h40, 8'h7f, 2'h0);
    repeat (4) @(posedge clock);
    chk("dim", dimmed_luminance, 16'd1905);
    for (int m = 1; m < 4; m++) begin
      cathode_supply_mode <= 2'(m);
      repeat (4) @(posedge clock);
      chk("dim", dimmed_luminance, 16'd1500);
    end
    cathode_supply_mode <= 2'h0;
    repeat (4) @(posedge clock);
    chk("dim", dimmed_luminance, 16'd1905);
  endtask
  task automatic t_temp;
    sensor_code <= 8'h40;
    wr(8'h44, 8'h10, 2'h0);
    wr(8'h48, 8'h80, 2'h0);
    wr(8'h4c, 8'h02, 2'h0);
    frames(2);
    chk("refr", refr, 0);
    frames(1);
    chk("refr", refr, 1);
    chk("ro", temp_readout, ro(64, 16, 128));
    sensor_code <= 8'hff;
    wr(8'h44, 8'h3f, 2'h0);
    wr(8'h48, 8'hff, 2'h0);
    frames(3);
    chk("ro", temp_readout, 8'hff);
    sensor_code <= 8'h00;
    wr(8'h48, 8'h00, 2'h0);
    frames(3);
    chk("ro", temp_readout, 8'h00);
  endtask
  task automatic t_pd;
    int n;
    n = refr;
    sensor_code <= 8'hc8;
    wr(8'h44, 8'h19, 2'h0);
    wr(8'h54, 8'h02, 2'h0);
    frames(3);
    chk("refr", refr, n);
    chk("ro", temp_readout, 8'h00);
    wr(8'h54, 8'h00, 2'h0);
    frames(3);
    chk("refr", refr, n + 1);
    chk("ro", temp_readout, ro(200, 25, 0));
    // Host offset for an ambient of 60 C: 1.82*60 + 109 - 212
    wr(8'h48, 8'h06, 2'h0);
    frames(3);
    chk("refr", refr, n + 2);
    chk("ro", temp_readout, ro(200, 25, 6));
  endtask
  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 0;
    t_reset;
    t_regs;
    t_lum;
    t_temp;
    t_pd;
    end_of_test;
  end
  initial begin
    #200000;
    miscompares++;
    end_of_test;
  end
endmodule // testbench
